// file: rtl/pxcrc_pkg.sv
// Package for the pixel path CRC tester: register indexes, field layout, CRC constants.
// Assumes an indexed register port with 16-bit index and 8-bit data.
package pxcrc_pkg;
  localparam logic [15:0] IDX_CONTROL   = 16'hffd6;
  localparam logic [15:0] IDX_RESULT_LO = 16'hffd7;
  localparam logic [15:0] IDX_RESULT_HI = 16'hffd8;
  localparam int          CH_MSB        = 7;
  localparam int          CH_LSB        = 6;
  localparam int          BITSEL_MSB    = 5;
  localparam int          BITSEL_LSB    = 3;
  localparam int          START_BIT     = 2;
  localparam int          SOURCE_BIT    = 1;
  localparam logic [1:0]  CH_BLUE       = 2'h0;
  localparam logic [1:0]  CH_GREEN      = 2'h1;
  localparam logic [1:0]  CH_RED        = 2'h2;
  localparam logic [7:0]  CONTROL_RESET = 8'h04;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [15:0] CRC_SEED      = 16'h0000;
  localparam logic [23:0] PATTERN_STEP  = 24'h010101;
endpackage : pxcrc_pkg

// file: rtl/pxcrc_sample_if.sv
// Interface carrying one gated sample from the pixel side to the CRC engine.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface pxcrc_sample_if;
  logic valid;
  logic data;
  logic start;
  modport src (output valid, output data, output start);
  modport dst (input valid, input data, input start);
endinterface : pxcrc_sample_if

// file: rtl/pxcrc_engine.sv
// CRC engine: 16-bit signature updated once per gated sample.
// Assumes samples arrive as one-cycle valid pulses on the system clock.
`timescale 1ns/1ps
module pxcrc_engine (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  pxcrc_sample_if.dst     smp,
  output logic [15:0]     crc_o
);
  logic [15:0] crc_reg;
  logic        fb;
  assign fb = crc_reg[15] ^ smp.data;
  // Result is deliberately left out of reset so it survives a register reset
  always_ff @(posedge clk_i)
  begin
    if (smp.start)
      crc_reg <= pxcrc_pkg::CRC_SEED;
    else if (smp.valid)
      crc_reg <= {crc_reg[14:0], 1'b0} ^ (fb ? pxcrc_pkg::CRC_POLY : 16'h0000);
  end
  assign crc_o = crc_reg;
  a_seed_on_start: assert property (@(posedge clk_i) disable iff (!rstn_i)
    smp.start |=> crc_reg == pxcrc_pkg::CRC_SEED)
    else $error("crc not seeded after start");
  a_hold_no_sample: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !smp.start && !smp.valid |=> $stable(crc_reg))
    else $error("crc changed without sample");
endmodule : pxcrc_engine

// file: rtl/pxcrc_top.sv
// Pixel path CRC tester top: indexed register port, pixel sampling, pattern source.
// Assumes PCLK and DOTCLK are free-running inputs slower than CLK_I by at least 4x.
//
// Summary of operation
// - Colour channel selected by bits 7-6, bit within it by bits 5-3.
// - Samples enter the CRC only while blanking marks active display.
// - Start bit going one to zero seeds and starts accumulation; resets to one.
// - Source bit selects pixel bus (0) or internal test pattern (1).
// - CRC result readable as low byte and high byte; reset leaves them.
// - Sync waveforms never reach the CRC, only gated pixel data or the test pattern.
// - CRC covers one selected bit per sample of the pixel words latched from PIXEL_I, or of the test pattern.
// - Pixel words latched on pixel clock rise; blanking rise marks first word.
`timescale 1ns/1ps
module pxcrc_top (
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic [15:0] REG_INDEX_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [7:0]  REG_RDATA_O,
  input  wire logic        PCLK_I,
  input  wire logic        DOTCLK_I,
  input  wire logic        BLANK_N_I,
  input  wire logic        MODE_MIX_SELECT_I,
  input  wire logic [15:0] PIXEL_I
);
  logic [7:0]  control_reg;
  logic [7:0]  rdata_reg;
  logic [15:0] crc;
  logic [1:0]  pclk_sync_reg;
  logic [1:0]  dot_sync_reg;
  logic [1:0]  blank_sync_reg;
  logic        pclk_d_reg;
  logic        dot_d_reg;
  logic        pclk_rise;
  logic        dot_rise;
  logic [15:0] pixel_reg;
  logic        blank_lat_reg;
  logic        blank_prev_reg;
  logic [15:0] pixel_meta_reg;
  logic [15:0] pixel_sync_reg;
  logic [23:0] rgb_reg;
  logic [23:0] pattern_reg;
  logic [23:0] rgb_sel;
  logic        start_pulse;
  logic        sample_bit;
  pxcrc_sample_if smp ();

  function automatic logic pick_bit(input logic [23:0] rgb, input logic [1:0] ch,
                                    input logic [2:0] sel);
    logic [7:0] chan;
    chan = 8'h00;
    case (ch)
      pxcrc_pkg::CH_BLUE:  chan = rgb[7:0];
      pxcrc_pkg::CH_GREEN: chan = rgb[15:8];
      pxcrc_pkg::CH_RED:   chan = rgb[23:16];
      default:             chan = 8'h00;
    endcase
    return chan[sel];
  endfunction : pick_bit

  // Register port; start bit resets to one, selection fields keep their value
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      control_reg[pxcrc_pkg::START_BIT] <= 1'b1;
      control_reg[0]                    <= 1'b0;
    end
    else if (REG_WR_I && REG_INDEX_I == pxcrc_pkg::IDX_CONTROL)
      control_reg <= {REG_WDATA_I[7:1], 1'b0};
  end
  // Edge is taken against the stored bit, so rewriting zero does not restart
  assign start_pulse = REG_WR_I && REG_INDEX_I == pxcrc_pkg::IDX_CONTROL
                       && control_reg[pxcrc_pkg::START_BIT]
                       && !REG_WDATA_I[pxcrc_pkg::START_BIT];

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      rdata_reg <= 8'h00;
    else if (REG_RD_I)
    begin
      case (REG_INDEX_I)
        pxcrc_pkg::IDX_CONTROL:   rdata_reg <= control_reg;
        pxcrc_pkg::IDX_RESULT_LO: rdata_reg <= crc[7:0];
        pxcrc_pkg::IDX_RESULT_HI: rdata_reg <= crc[15:8];
        default:                  rdata_reg <= 8'h00;
      endcase
    end
  end
  // Results are read live; set the start bit first to freeze them
  assign REG_RDATA_O = rdata_reg;

  // Two-stage synchronisers; only stage two feeds logic
  // Pixel bus is stable for many clocks around the pixel clock rise, so bits cannot tear
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      pclk_sync_reg  <= 2'h0;
      dot_sync_reg   <= 2'h0;
      blank_sync_reg <= 2'h0;
      pixel_meta_reg <= 16'h0000;
      pixel_sync_reg <= 16'h0000;
      pclk_d_reg     <= 1'b0;
      dot_d_reg      <= 1'b0;
    end
    else
    begin
      pclk_sync_reg  <= {pclk_sync_reg[0], PCLK_I};
      dot_sync_reg   <= {dot_sync_reg[0], DOTCLK_I};
      blank_sync_reg <= {blank_sync_reg[0], BLANK_N_I};
      pixel_meta_reg <= PIXEL_I;
      pixel_sync_reg <= pixel_meta_reg;
      pclk_d_reg     <= pclk_sync_reg[1];
      dot_d_reg      <= dot_sync_reg[1];
    end
  end
  assign pclk_rise = pclk_sync_reg[1] && !pclk_d_reg;
  assign dot_rise  = dot_sync_reg[1] && !dot_d_reg;

  // Synchronised pixel bus is latched on the detected pixel clock rise
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      pixel_reg      <= 16'h0000;
      blank_lat_reg  <= 1'b0;
      blank_prev_reg <= 1'b0;
      rgb_reg        <= 24'h000000;
    end
    else if (pclk_rise)
    begin
      pixel_reg      <= pixel_sync_reg;
      blank_lat_reg  <= blank_sync_reg[1];
      blank_prev_reg <= blank_lat_reg;
      // Low bytes first; blanking rise restarts word order
      if (blank_lat_reg && !blank_prev_reg)
        rgb_reg <= {8'h00, pixel_reg};
      else
        rgb_reg <= {pixel_reg[7:0], rgb_reg[15:0]};
    end
  end

  // Pattern restarts with every CRC start so results repeat
  // It steps after each taken sample, so the first sample always sees zero
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I || start_pulse)
      pattern_reg <= 24'h000000;
    else if (smp.valid)
      pattern_reg <= pattern_reg + pxcrc_pkg::PATTERN_STEP;
  end

  assign rgb_sel = control_reg[pxcrc_pkg::SOURCE_BIT] ? pattern_reg : rgb_reg;
  assign sample_bit = pick_bit(rgb_sel, control_reg[pxcrc_pkg::CH_MSB:pxcrc_pkg::CH_LSB],
                               control_reg[pxcrc_pkg::BITSEL_MSB:pxcrc_pkg::BITSEL_LSB]);

  // No sync input exists here, so sync timing cannot reach the CRC
  // Delayed blanking lines up with the word now held in rgb_reg, so blanked words stay out
  assign smp.valid = dot_rise && blank_prev_reg && !control_reg[pxcrc_pkg::START_BIT]
                     && RSTN_I;
  assign smp.data  = sample_bit;
  assign smp.start = start_pulse;

  pxcrc_engine u_engine (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .smp    (smp),
    .crc_o  (crc)
  );

  a_gate_blank: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    smp.valid |-> blank_prev_reg && dot_rise)
    else $error("sample outside active display");
  a_idle_when_set: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    control_reg[pxcrc_pkg::START_BIT] |-> !smp.valid)
    else $error("accumulating while start bit set");
  a_start_edge: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    start_pulse |=> !control_reg[pxcrc_pkg::START_BIT])
    else $error("start bit not cleared by start write");
  a_none_channel: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    control_reg[7:6] == 2'h3 |-> !sample_bit)
    else $error("none selection fed data");
  a_pattern_src: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    control_reg[pxcrc_pkg::SOURCE_BIT] |-> rgb_sel == pattern_reg)
    else $error("pattern source not used");
  a_pattern_restart: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    start_pulse |=> pattern_reg == 24'h000000)
    else $error("pattern not restarted");
  a_pattern_step: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    smp.valid |=> pattern_reg == $past(pattern_reg) + pxcrc_pkg::PATTERN_STEP)
    else $error("pattern did not step after sample");
  a_pattern_hold: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !smp.valid && !start_pulse |=> $stable(pattern_reg))
    else $error("pattern moved without sample");
  a_one_update: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    smp.valid |=> !smp.valid)
    else $error("more than one update per dot clock");
  a_rgb_first: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    pclk_rise && blank_lat_reg && !blank_prev_reg |=> rgb_reg[23:16] == 8'h00)
    else $error("first word after blanking not restarted");
  a_read_low: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    REG_RD_I && REG_INDEX_I == pxcrc_pkg::IDX_RESULT_LO |=> REG_RDATA_O == $past(crc[7:0]))
    else $error("low byte read mismatch");
  a_read_high: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    REG_RD_I && REG_INDEX_I == pxcrc_pkg::IDX_RESULT_HI |=> REG_RDATA_O == $past(crc[15:8]))
    else $error("high byte read mismatch");
  a_latch_pclk: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !pclk_rise |=> $stable(pixel_reg))
    else $error("pixel latched off pixel clock edge");
endmodule : pxcrc_top

// file: dv/pxcrc_gfx_model.sv
// Graphics controller model: drives pixel clock, dot clock, blanking and pixel bus.
// Assumes the bench calls run() from one process at a time.
`timescale 1ns/1ps
module pxcrc_gfx_model (
  output logic        pclk_o,
  output logic        dotclk_o,
  output logic        blank_n_o,
  output logic [15:0] pixel_o
);
  initial
  begin
    pclk_o    = 1'h0;
    blank_n_o = 1'h0;
    pixel_o   = 16'h0000;
  end
  // One dot per pixel word keeps the sample count equal to the pixel count
  assign dotclk_o = pclk_o;
  // Clock stands still between frames; data moves on the low half only
  task automatic run(input int n, input logic blank, input logic [15:0] word);
    for (int i = 0; i < n; i++)
    begin
      blank_n_o = blank;
      pixel_o   = blank ? word : ~pixel_o;
      #40 pclk_o = 1'h1;
      #40 pclk_o = 1'h0;
    end
  endtask : run
endmodule : pxcrc_gfx_model

// file: dv/pxcrc_tb_top.sv
// Self-checking bench for the pixel path CRC tester.
// Assumes the graphics controller model and the design package are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module pxcrc_tb_top;
  logic        clk_i, rstn_i, reg_wr_i, reg_rd_i, pclk_i, dotclk_i, blank_n_i;
  logic [15:0] reg_index_i, pixel_i, crc, crc2;
  logic [7:0]  reg_wdata_i, reg_rdata_o, rv, b;
  logic [1:0]  ch;
  logic [2:0]  bs;
  logic        src;
  int          bad_count, comparisons, n;
  pxcrc_top pxcrc_top_inst (.CLK_I(clk_i), .RSTN_I(rstn_i), .REG_INDEX_I(reg_index_i),
    .REG_WDATA_I(reg_wdata_i), .REG_WR_I(reg_wr_i), .REG_RD_I(reg_rd_i),
    .REG_RDATA_O(reg_rdata_o), .PCLK_I(pclk_i), .DOTCLK_I(dotclk_i),
    .BLANK_N_I(blank_n_i), .MODE_MIX_SELECT_I(1'h0), .PIXEL_I(pixel_i));
  pxcrc_gfx_model pxcrc_gfx_model_inst (.pclk_o(pclk_i), .dotclk_o(dotclk_i),
    .blank_n_o(blank_n_i), .pixel_o(pixel_i));
  function automatic logic [15:0] crc_exp(input logic [1:0] c_sel, input logic [2:0] b_sel,
    input logic pat, input logic [7:0] byt, input int cnt);
    logic [15:0] c;
    logic [7:0]  v;
    logic        d;
    c = pxcrc_pkg::CRC_SEED;
    for (int i = 0; i < cnt; i++)
    begin
      v = pat ? 8'(i) : byt;
      d = (c_sel == 2'h3) ? 1'h0 : v[b_sel];
      c = {c[14:0], 1'h0} ^ ((c[15] ^ d) ? pxcrc_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction : crc_exp
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    #1 {reg_index_i, reg_wdata_i, reg_wr_i} = {idx, d, 1'h1};
    @(posedge clk_i);
    #1 reg_wr_i = 1'h0;
  endtask : wr
  task automatic rd(input logic [15:0] idx, output logic [7:0] d);
    @(posedge clk_i);
    #1 {reg_index_i, reg_rd_i} = {idx, 1'h1};
    @(posedge clk_i);
    #1 reg_rd_i = 1'h0;
    d = reg_rdata_o;
  endtask : rd
  task automatic rd_crc(output logic [15:0] c);
    rd(pxcrc_pkg::IDX_RESULT_LO, c[7:0]);
    rd(pxcrc_pkg::IDX_RESULT_HI, c[15:8]);
  endtask : rd_crc
  task automatic test_done;
    $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  initial
  begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Only hang guard; every other wait has a fixed length
  initial
  begin
    #400000 bad_count++;
    test_done();
  end
  initial
  begin
    {rstn_i, reg_wr_i, reg_rd_i, reg_index_i, reg_wdata_i} = '0;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(4));
    repeat (20) @(posedge clk_i);
    #1 rstn_i = 1'h1;
    rd(pxcrc_pkg::IDX_CONTROL, rv);
    `CHK("start bit reset", 8'h04, rv & 8'h04)
    rd(16'h0000, rv);
    `CHK("unmapped read", 8'h00, rv)
    wr(pxcrc_pkg::IDX_CONTROL, 8'hab);
    rd(pxcrc_pkg::IDX_CONTROL, rv);
    `CHK("control readback", 8'haa, rv)
    for (int t = 0; t < 12; t++)
    begin
      src = 1'($urandom_range(1, 0));
      ch = src ? 2'($urandom_range(3, 0)) : 2'($urandom_range(1, 0));
      bs = 3'($urandom_range(7, 0));
      b = (t == 0) ? 8'hff : 8'($urandom_range(255, 0));
      n = (t == 1) ? 1 : $urandom_range(40, 2);
      wr(pxcrc_pkg::IDX_CONTROL, {ch, bs, 1'h1, src, 1'h0});
      wr(pxcrc_pkg::IDX_CONTROL, {ch, bs, 1'h0, src, 1'h0});
      pxcrc_gfx_model_inst.run(3, 1'h0, {b, b});
      pxcrc_gfx_model_inst.run(n, 1'h1, {b, b});
      pxcrc_gfx_model_inst.run(3, 1'h0, {b, b});
      wr(pxcrc_pkg::IDX_CONTROL, {ch, bs, 1'h1, src, 1'h0});
      rd_crc(crc);
      `CHK("crc result", crc_exp(ch, bs, src, b, n), crc)
    end
    wr(pxcrc_pkg::IDX_RESULT_LO, ~crc[7:0]);
    wr(pxcrc_pkg::IDX_RESULT_HI, ~crc[15:8]);
    rd_crc(crc2);
    `CHK("result read only", crc, crc2)
    @(posedge clk_i);
    #1 rstn_i = 1'h0;
    repeat (3) @(posedge clk_i);
    #1 rstn_i = 1'h1;
    rd_crc(crc2);
    `CHK("result kept on reset", crc, crc2)
    wr(pxcrc_pkg::IDX_CONTROL, 8'h00);
    pxcrc_gfx_model_inst.run(5, 1'h0, 16'h5555);
    wr(pxcrc_pkg::IDX_CONTROL, 8'h04);
    rd_crc(crc2);
    `CHK("restart with blanking", 16'h0000, crc2)
    test_done();
  end
endmodule : pxcrc_tb_top
